// ===== logic/pulse_generator_and_edge_scalers.sv
// pulse-train generator and saturating edge counter bank with host register port
`timescale 1ns/100ps
`include "pulse_scaler_params.svh"

module pulse_generator_and_edge_scalers (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [`ADDR_W-1:0]            reg_addr,
    input  wire logic [31:0]                   reg_wdata,
    output logic      [31:0]                   reg_rdata,
    output logic                               reg_rvalid,
    input  wire pulse_scaler_pkg::monitor_pins_t monitor_pins,
    output logic                               pulse_out,
    output logic                               pulse_done
);

    localparam int NUM  = `COUNTER_NUM;
    localparam int MW   = $bits(pulse_scaler_pkg::monitor_pins_t);

    // register file
    logic [31:0] period_q;
    logic [31:0] low_time_q;
    logic [31:0] count_limit_q;
    logic        freeze_q;

    // generator
    pulse_scaler_pkg::gen_state_t state_q;
    logic [31:0] phase_q;
    logic [31:0] delivered_q;
    logic        pulse_out_q;
    logic        pulse_done_q;
    logic [`TICK_DIV_W-1:0] tick_div_q;
    logic        tick_en;

    // bus read
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic [31:0] rdata_d;

    // counters
    logic [31:0] cnt_q [NUM];
    logic [MW-1:0] meta_q;
    logic [MW-1:0] sync_q;
    logic [MW-1:0] prev_q;
    pulse_scaler_pkg::monitor_pins_t lvl;
    pulse_scaler_pkg::monitor_pins_t old;
    logic [NUM-1:0] inc;

    logic launch_wr;
    logic clear_cnt;
    logic period_end;
    logic last_period;
    logic endless;
    logic [`ADDR_W-1:0] cnt_ofs;
    logic [`COUNTER_IDX_W-1:0] cnt_idx;
    logic cnt_hit;

    assign launch_wr   = reg_wr && (reg_addr == `LAUNCH_OFS);
    assign clear_cnt   = reg_wr && (reg_addr == `FREEZE_OFS) && !reg_wdata[0];
    assign endless     = (count_limit_q == `COUNT_ENDLESS);
    assign period_end  = (state_q == pulse_scaler_pkg::GEN_RUN) && tick_en && (phase_q == period_q - 32'h00000001);
    assign last_period = !endless && (delivered_q == count_limit_q - 32'h00000001);

    // ------------------------------------------------------------------ registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_q      <= `REG_RESET;
            low_time_q    <= `REG_RESET;
            count_limit_q <= `REG_RESET;
            freeze_q      <= 1'b0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `PERIOD_OFS:      period_q      <= reg_wdata;
                `LOW_TIME_OFS:    low_time_q    <= reg_wdata;
                `COUNT_LIMIT_OFS: count_limit_q <= reg_wdata;
                `FREEZE_OFS:      freeze_q      <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------ tick divider
    always_ff @(posedge clk) begin
        if (!rst_n || tick_en) begin
            tick_div_q <= '0;
        end else begin
            tick_div_q <= tick_div_q + `TICK_DIV_W'(1);
        end
    end
    assign tick_en = (tick_div_q == `TICK_DIV_W'(`TICK_CYCLES - 1));

    // ------------------------------------------------------------------ generator state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= pulse_scaler_pkg::GEN_IDLE;
        end else if (count_limit_q == `COUNT_DISABLED) begin
            state_q <= pulse_scaler_pkg::GEN_IDLE;
        end else if (launch_wr) begin
            // a zero period cannot hold a tick, so it never starts
            state_q <= (period_q != 32'h00000000) ? pulse_scaler_pkg::GEN_RUN
                                                  : pulse_scaler_pkg::GEN_IDLE;
        end else if (period_end && last_period) begin
            state_q <= pulse_scaler_pkg::GEN_IDLE;
        end
    end

    // phase within the period and number of periods delivered
    always_ff @(posedge clk) begin
        if (!rst_n || launch_wr) begin
            phase_q     <= 32'h00000000;
            delivered_q <= 32'h00000000;
        end else if (period_end) begin
            phase_q     <= 32'h00000000;
            delivered_q <= endless ? delivered_q : delivered_q + 32'h00000001;
        end else if (state_q == pulse_scaler_pkg::GEN_RUN && tick_en) begin
            phase_q     <= phase_q + 32'h00000001;
        end
    end

    // low phase first, then high for the remainder of the period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_out_q  <= 1'b0;
            pulse_done_q <= 1'b1;
        end else begin
            pulse_out_q  <= (state_q == pulse_scaler_pkg::GEN_RUN) && (phase_q >= low_time_q);
            pulse_done_q <= (state_q == pulse_scaler_pkg::GEN_IDLE);
        end
    end

    assign pulse_out  = pulse_out_q;
    assign pulse_done = pulse_done_q;

    // ------------------------------------------------------------------ edge counters
    // three stages: two for metastability, one as the edge reference
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= monitor_pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign lvl = sync_q;
    assign old = prev_q;

    // index map; the global clock is sampled, so above 25 MHz it undercounts
    assign inc = {
        lvl.rear_lvds_out  & ~old.rear_lvds_out,
        lvl.rear_lvds_in   & ~old.rear_lvds_in,
        lvl.busy,
        lvl.busy           & ~old.busy,
        lvl.front_lvds_out & ~old.front_lvds_out,
        lvl.front_lvds_in  & ~old.front_lvds_in,
        lvl.front_nim_out  & ~old.front_nim_out,
        lvl.backplane_trig & ~old.backplane_trig,
        lvl.backplane_sync & ~old.backplane_sync,
        lvl.global_clk     & ~old.global_clk,
        1'b1
    };

    generate
        for (genvar i = 0; i < NUM; i++) begin : g_cnt
            always_ff @(posedge clk) begin
                if (!rst_n || clear_cnt) begin
                    cnt_q[i] <= 32'h00000000;
                end else if (!freeze_q && inc[i] && cnt_q[i] != `COUNTER_FULL) begin
                    cnt_q[i] <= cnt_q[i] + 32'h00000001;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------ read port
    assign cnt_ofs = reg_addr - `COUNTER_BASE_OFS;
    assign cnt_idx = cnt_ofs[`COUNTER_IDX_W+1:2];
    assign cnt_hit = (reg_addr >= `COUNTER_BASE_OFS) && (cnt_ofs[1:0] == 2'h0)
                  && (cnt_ofs[`ADDR_W-1:`COUNTER_IDX_W+2] == '0) && (cnt_idx <= `COUNTER_LAST_IDX);

    always_comb begin
        rdata_d = 32'h00000000;
        if (cnt_hit) begin
            rdata_d = cnt_q[cnt_idx];
        end else begin
            unique case (reg_addr)
                `PERIOD_OFS:      rdata_d = period_q;
                `LOW_TIME_OFS:    rdata_d = low_time_q;
                `COUNT_LIMIT_OFS: rdata_d = count_limit_q;
                `STATE_OFS:       rdata_d = {31'h00000000, state_q == pulse_scaler_pkg::GEN_IDLE};
                `FREEZE_OFS:      rdata_d = {31'h00000000, freeze_q};
                default:          rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q  <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= reg_rd ? rdata_d : 32'h00000000;
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ------------------------------------------------------------------ checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_period_wrap: assert property (
        period_end && !last_period && !launch_wr && count_limit_q != `COUNT_DISABLED |=> phase_q == 32'h00000000)
        else $error("phase did not wrap at end of period");

    chk_low_phase: assert property (
        state_q == pulse_scaler_pkg::GEN_RUN && phase_q < low_time_q |=> !pulse_out_q)
        else $error("output high during low phase");

    chk_high_phase: assert property (
        state_q == pulse_scaler_pkg::GEN_RUN && phase_q >= low_time_q |=> pulse_out_q)
        else $error("output low during high phase");

    chk_zero_disable: assert property (
        count_limit_q == `COUNT_DISABLED |=> state_q == pulse_scaler_pkg::GEN_IDLE ##1 !pulse_out_q)
        else $error("generator ran with zero count");

    chk_endless_run: assert property (
        state_q == pulse_scaler_pkg::GEN_RUN && endless && !reg_wr |=> state_q == pulse_scaler_pkg::GEN_RUN)
        else $error("endless train stopped");

    chk_launch_clear: assert property (
        launch_wr && count_limit_q != `COUNT_DISABLED && period_q != 32'h00000000
        |=> state_q == pulse_scaler_pkg::GEN_RUN && delivered_q == 32'h00000000 && phase_q == 32'h00000000)
        else $error("launch write did not restart train");

    chk_state_read: assert property (
        reg_rd && reg_addr == `STATE_OFS |=> reg_rvalid && reg_rdata[0] == $past(state_q == pulse_scaler_pkg::GEN_IDLE))
        else $error("completion bit read wrong");

    chk_done_flag: assert property (
        state_q == pulse_scaler_pkg::GEN_IDLE |=> pulse_done_q)
        else $error("done flag low while idle");

    chk_finite_end: assert property (
        period_end && last_period && !reg_wr
        |=> state_q == pulse_scaler_pkg::GEN_IDLE ##1 !pulse_out_q && pulse_done_q)
        else $error("finite train did not end low");

    chk_freeze_hold: assert property (
        freeze_q && !clear_cnt |=> cnt_q[`IDX_BUSY_TIME] == $past(cnt_q[`IDX_BUSY_TIME]))
        else $error("counter moved while frozen");

    chk_clear_zero: assert property (
        clear_cnt |=> cnt_q[`IDX_REF_CLOCK] == 32'h00000000 ##1 cnt_q[`IDX_REF_CLOCK] == 32'h00000001)
        else $error("counters not cleared on unfreeze");

    chk_saturate: assert property (
        cnt_q[`IDX_REF_CLOCK] == `COUNTER_FULL && !clear_cnt |=> cnt_q[`IDX_REF_CLOCK] == `COUNTER_FULL)
        else $error("counter wrapped past all ones");

    chk_ref_count: assert property (
        !freeze_q && !clear_cnt && cnt_q[`IDX_REF_CLOCK] != `COUNTER_FULL
        |=> cnt_q[`IDX_REF_CLOCK] == $past(cnt_q[`IDX_REF_CLOCK]) + 32'h00000001)
        else $error("reference counter missed a cycle");

    chk_done_busy: assert property (
        state_q == pulse_scaler_pkg::GEN_RUN |=> !pulse_done_q)
        else $error("done flag high while running");

    chk_zero_period: assert property (
        launch_wr && period_q == 32'h00000000 |=> state_q == pulse_scaler_pkg::GEN_IDLE)
        else $error("launch with zero period started a train");

    chk_period_step: assert property (
        period_end && !endless && !launch_wr |=> delivered_q == $past(delivered_q) + 32'h00000001)
        else $error("delivered periods not counted");

    chk_endless_hold: assert property (
        endless && !launch_wr |=> delivered_q == $past(delivered_q))
        else $error("endless train counted periods");

    chk_sync_chain: assert property (
        1'b1 |=> sync_q == $past(meta_q) && prev_q == $past(sync_q))
        else $error("synchroniser stage skipped");

    chk_edge_count: assert property (
        !freeze_q && !clear_cnt && lvl.backplane_sync && !old.backplane_sync
        && cnt_q[`IDX_BACKPLANE_SYNC] != `COUNTER_FULL
        |=> cnt_q[`IDX_BACKPLANE_SYNC] == $past(cnt_q[`IDX_BACKPLANE_SYNC]) + 32'h00000001)
        else $error("rising edge not counted");

    chk_edge_once: assert property (
        !clear_cnt && !(lvl.backplane_sync && !old.backplane_sync)
        |=> cnt_q[`IDX_BACKPLANE_SYNC] == $past(cnt_q[`IDX_BACKPLANE_SYNC]))
        else $error("counter moved without an edge");

    chk_busy_time: assert property (
        !freeze_q && !clear_cnt && lvl.busy && cnt_q[`IDX_BUSY_TIME] != `COUNTER_FULL
        |=> cnt_q[`IDX_BUSY_TIME] == $past(cnt_q[`IDX_BUSY_TIME]) + 32'h00000001)
        else $error("busy cycle not counted");

    chk_counter_read: assert property (
        reg_rd && cnt_hit |=> reg_rvalid && reg_rdata == $past(cnt_q[cnt_idx]))
        else $error("counter read returned wrong word");

    chk_read_quiet: assert property (
        !reg_rd |=> !reg_rvalid && reg_rdata == 32'h00000000)
        else $error("read answer without a request");

endmodule : pulse_generator_and_edge_scalers

// ===== logic/pulse_scaler_params.svh
// register offsets, reset values and timing counts for the pulse generator and edge counters
`ifndef PULSE_SCALER_PARAMS_SVH
`define PULSE_SCALER_PARAMS_SVH

`define ADDR_W              16
`define PERIOD_OFS          16'h0080
`define LOW_TIME_OFS        16'h0084
`define COUNT_LIMIT_OFS     16'h0088
`define LAUNCH_OFS          16'h008C
`define STATE_OFS           16'h0090
`define FREEZE_OFS          16'h0100
`define COUNTER_BASE_OFS    16'h0104
`define COUNTER_NUM         35
`define COUNTER_IDX_W       6
`define COUNTER_LAST_IDX    6'h22

`define REG_RESET           32'h00000000
`define COUNT_DISABLED      32'h00000000
`define COUNT_ENDLESS       32'h0FFFFFFF
`define COUNTER_FULL        32'hFFFFFFFF

`define TICK_NS             4
`define CLK_PERIOD_NS       20
// a tick shorter than a clock period rounds up to one cycle
`define TICK_CYCLES         (((`TICK_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define TICK_DIV_W          4

`define IDX_REF_CLOCK       0
`define IDX_BACKPLANE_SYNC  2
`define IDX_BUSY_TIME       18

`endif

// ===== logic/pulse_scaler_pkg.sv
// types shared by the pulse generator and edge counter block
package pulse_scaler_pkg;

    typedef enum logic [0:0] {
        GEN_IDLE,
        GEN_RUN
    } gen_state_t;

    // monitored levels, all asynchronous to clk
    typedef struct packed {
        logic [7:0] rear_lvds_out;
        logic [7:0] rear_lvds_in;
        logic       busy;
        logic [4:0] front_lvds_out;
        logic [4:0] front_lvds_in;
        logic [1:0] front_nim_out;
        logic [1:0] backplane_trig;
        logic       backplane_sync;
        logic       global_clk;
    } monitor_pins_t;

endpackage : pulse_scaler_pkg

// ===== sim/tb_top.sv
// self-checking bench for the pulse generator and edge counter block
`timescale 1ns/100ps
`include "pulse_scaler_params.svh"

module tb_top;
    typedef struct {
        logic [15:0] a;
        logic        w;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;

    logic                            clk;
    logic                            rst_n;
    logic                            reg_wr;
    logic                            reg_rd;
    logic [15:0]                     reg_addr;
    logic [31:0]                     reg_wdata;
    logic [31:0]                     reg_rdata;
    logic                            reg_rvalid;
    pulse_scaler_pkg::monitor_pins_t pins;
    logic                            pulse_out;
    logic                            pulse_done;
    int                              error_cnt;
    int                              n_tests;
    int                              cyc;
    int                              hi_cnt;
    int                              rise_cnt;
    logic                            prev_out;
    time                             t_clr;
    time                             t_frz;
    logic [31:0]                     v;

    row_t rows [15] = '{
        '{16'h0080, 1'b0, 32'h00000000, 32'h00000000}, '{16'h0084, 1'b0, 32'h00000000, 32'h00000000},
        '{16'h0088, 1'b0, 32'h00000000, 32'h00000000}, '{16'h0090, 1'b0, 32'h00000000, 32'h00000001},
        '{16'h0100, 1'b0, 32'h00000000, 32'h00000000}, '{16'h010C, 1'b0, 32'h00000000, 32'h00000000},
        '{16'h0080, 1'b1, 32'h12345678, 32'h12345678}, '{16'h0084, 1'b1, 32'hA5A5A5A5, 32'hA5A5A5A5},
        '{16'h0088, 1'b1, 32'h00000000, 32'h00000000}, '{16'h008C, 1'b1, 32'hFFFFFFFF, 32'h00000000},
        '{16'h0200, 1'b1, 32'hDEADBEEF, 32'h00000000}, '{16'h0102, 1'b1, 32'h00000001, 32'h00000000},
        '{16'h0100, 1'b1, 32'h00000001, 32'h00000001}, '{16'h0100, 1'b1, 32'h00000000, 32'h00000000},
        '{16'h0108, 1'b1, 32'h0000FFFF, 32'h00000000}
    };

    pulse_generator_and_edge_scalers u_pulse_generator_and_edge_scalers (
        .clk          (clk),
        .rst_n        (rst_n),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_rdata    (reg_rdata),
        .reg_rvalid   (reg_rvalid),
        .monitor_pins (pins),
        .pulse_out    (pulse_out),
        .pulse_done   (pulse_done)
    );

    always #10 clk = ~clk;

    // shape of the generator output, seen mid-cycle where it is settled
    always @(negedge clk) begin
        cyc++;
        if (pulse_out === 1'b1) hi_cnt++;
        if (pulse_out === 1'b1 && prev_out !== 1'b1) rise_cnt++;
        prev_out = pulse_out;
        if (cyc == 6000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
        // idle edge, so a following strobe never changes twice in one step
        tick(1);
    endtask : wr

    // read answer is awaited for at most two edges
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        tick(1);
        reg_rd = 1'b0;
        if (reg_rvalid !== 1'b1) tick(1);
        chk({31'h0, reg_rvalid}, 32'h1, "read answer");
        d = reg_rdata;
        tick(1);
        chk({31'h0, reg_rvalid} | reg_rdata, 32'h00000000, "read answer ends");
    endtask : rd

    function automatic logic [32:0] pulse_mask(input int p);
        for (int b = 0; b < 33; b++) pulse_mask[b] = (p < (b % 3) + 1);
    endfunction : pulse_mask

    function automatic logic [31:0] exp_cnt(input int i);
        int b;
        b = (i <= 17) ? i - 1 : i - 2;
        if (i == 18) return 32'h00000006;
        return 32'((b % 3) + 1);
    endfunction : exp_cnt

    initial begin
        clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 16'h0000; reg_wdata = 32'h00000000; pins = '0;
        error_cnt = 0; n_tests = 0; cyc = 0; hi_cnt = 0; rise_cnt = 0; prev_out = 1'b0;
        tick(16);
        rst_n = 1'b1;
        foreach (rows[k]) begin
            if (rows[k].w) wr(rows[k].a, rows[k].d);
            rd(rows[k].a, v);
            chk(v, rows[k].e, "register row");
        end
        // edges on every monitored pin, one to three per pin by bit position
        wr(16'h0100, 32'h00000000);
        t_clr = $time;
        for (int p = 0; p < 3; p++) begin
            pins = pulse_mask(p);
            tick(3);
            pins = '0;
            tick(3);
        end
        tick(4);
        wr(16'h0100, 32'h00000001);
        t_frz = $time;
        // frozen counters must ignore this pulse
        pins = '1;
        tick(3);
        pins = '0;
        tick(4);
        rd(16'h0104, v);
        chk(v, 32'((t_frz - t_clr) / 20), "reference count");
        for (int i = 1; i < 35; i++) begin
            rd(16'(16'h0104 + i * 4), v);
            chk(v, exp_cnt(i), "edge count");
        end
        wr(16'h0100, 32'h00000000);
        rd(16'h0108, v);
        chk(v, 32'h00000000, "cleared count");
        // finite train of three periods
        wr(16'h0080, 32'h00000004);
        wr(16'h0084, 32'h00000001);
        wr(16'h0088, 32'h00000003);
        hi_cnt = 0; rise_cnt = 0;
        wr(16'h008C, 32'h00000000);
        rd(16'h0090, v);
        chk(v, 32'h00000000, "busy status");
        chk({31'h0, pulse_done}, 32'h0, "done low");
        tick(30);
        chk(32'(hi_cnt), 32'h00000009, "high ticks");
        chk(32'(rise_cnt), 32'h00000003, "period count");
        chk({31'h0, pulse_out}, 32'h0, "ends low");
        rd(16'h0090, v);
        chk(v, 32'h00000001, "idle status");
        // endless code keeps going until the count is zeroed
        wr(16'h0088, 32'h0FFFFFFF);
        wr(16'h008C, 32'h00000001);
        rise_cnt = 0;
        tick(40);
        chk({31'h0, rise_cnt >= 9}, 32'h1, "endless periods");
        chk({31'h0, pulse_done}, 32'h0, "endless busy");
        wr(16'h0088, 32'h00000000);
        tick(4);
        chk({31'h0, pulse_done}, 32'h1, "zero count stops");
        // launch refused with count zero, then with period zero
        for (int k = 0; k < 2; k++) begin
            wr(16'h0080, k == 0 ? 32'h00000004 : 32'h00000000);
            wr(16'h0088, k == 0 ? 32'h00000000 : 32'h00000002);
            rise_cnt = 0;
            wr(16'h008C, 32'h00000001);
            tick(10);
            chk(32'(rise_cnt), 32'h00000000, "no output");
            chk({31'h0, pulse_done}, 32'h1, "stays idle");
        end
        // second reset while a train is running
        wr(16'h0080, 32'h00000007);
        wr(16'h008C, 32'h00000001);
        tick(3);
        chk({31'h0, pulse_done}, 32'h0, "running before reset");
        rst_n = 1'b0;
        tick(16);
        rst_n = 1'b1;
        chk({31'h0, pulse_done}, 32'h1, "done after reset");
        chk({31'h0, pulse_out}, 32'h0, "output low after reset");
        rd(16'h0080, v);
        chk(v, 32'h00000000, "period after reset");
        stop_test();
    end
endmodule : tb_top
